// File: core/vcf_bank.sv
// Command register bank with ramping output target and over-voltage fault response.
`timescale 1ns/1ps
module vcf_bank (
    input  wire logic              I_CLK_SYS,
    input  wire logic              I_RST,
    input  wire vcf_pkg::vcf_cmd_t I_CMD,
    input  wire logic [15:0]       I_STRAP_NOMINAL,
    input  wire logic [7:0]        I_VOUT_MODE,
    input  wire logic [15:0]       I_VOUT_COMMAND,
    input  wire logic              I_MARGIN_HIGH,
    input  wire logic              I_MARGIN_LOW,
    input  wire logic              I_ENABLE,
    input  wire logic              I_CLEAR_FAULTS,
    input  wire logic              I_CLEAR_OV_BIT,
    input  wire logic [15:0]       I_VIN_MEAS,
    input  wire logic [15:0]       I_VOUT_SENSE,
    input  wire logic [15:0]       I_IOUT_RAW,
    input  wire logic [15:0]       I_LOAD_CURRENT,
    input  wire logic [15:0]       I_DUTY_DEMAND,
    output logic [15:0]            O_RDATA,
    output logic                   O_RVALID,
    output logic                   O_WR_REFUSED,
    output logic                   O_CONVERTING,
    output logic                   O_OUTPUT_EN,
    output logic                   O_OV_FAULT,
    output logic [15:0]            O_VOUT_TARGET,
    output logic [15:0]            O_DUTY,
    output logic [15:0]            O_IOUT_REPORT,
    output logic [31:0]            O_VOUT_LOOP,
    output logic [31:0]            O_VOUT_MONITOR,
    output logic [4:0]             O_VOUT_EXP
);

    typedef struct packed {
        vcf_pkg::vcf_regs_t regs;
        vcf_pkg::vcf_run_t  run;
        logic [15:0]        target;
        logic [15:0]        tick;
        logic [15:0]        delay_cnt;
        logic [2:0]         retries;
        logic               ov_flag;
        logic               enable_q;
        logic [15:0]        rdata;
        logic               rvalid;
        logic               refused;
        logic [15:0]        duty;
        logic [15:0]        iout;
        logic [31:0]        vloop;
        logic [31:0]        vmon;
        logic [4:0]         vexp;
    } vcf_state_t;

    vcf_state_t st;
    vcf_state_t next_st;

    function automatic logic [15:0] clamp_ramp(input logic [15:0] v);
        if (v < vcf_pkg::RAMP_MIN) begin
            return vcf_pkg::RAMP_MIN;
        end else if (v > vcf_pkg::RAMP_MAX) begin
            return vcf_pkg::RAMP_MAX;
        end
        return v;
    endfunction

    function automatic logic [15:0] step_toward(input logic [15:0] cur,
                                                input logic [15:0] goal,
                                                input logic [15:0] step);
        if (cur < goal) begin
            return (goal - cur > step) ? 16'(cur + step) : goal;
        end else begin
            return (cur - goal > step) ? 16'(cur - step) : goal;
        end
    endfunction

    logic [23:0] ceil_lim;
    logic [23:0] ceil_req;
    logic [15:0] goal;
    logic [15:0] droop;
    logic        ov_now;
    logic        off_on;
    logic [1:0]  resp;
    logic [2:0]  retry_set;
    logic [15:0] delay_len;

    always_comb begin
        next_st         = st;
        next_st.rvalid  = 1'b0;
        next_st.refused = 1'b0;
        ceil_lim = 24'(I_STRAP_NOMINAL) * 24'(vcf_pkg::CEIL_NUM);
        ceil_req = 24'(I_CMD.wdata) * 24'(vcf_pkg::CEIL_DEN);
        resp      = st.regs.ov_resp[vcf_pkg::RESP_HI:vcf_pkg::RESP_LO];
        retry_set = st.regs.ov_resp[vcf_pkg::RETRY_HI:vcf_pkg::RETRY_LO];
        delay_len = 16'(st.regs.ov_resp[vcf_pkg::DELAY_HI:vcf_pkg::DELAY_LO])
                    * vcf_pkg::DELAY_UNIT_CYC;
        off_on = I_ENABLE && !st.enable_q;
        next_st.enable_q = I_ENABLE;

        if (I_CMD.wr) begin
            unique case (I_CMD.addr)
                vcf_pkg::ADDR_CEILING: begin
                    if (ceil_req > ceil_lim) begin
                        next_st.refused = 1'b1;
                    end else begin
                        next_st.regs.ceiling = I_CMD.wdata;
                    end
                end
                vcf_pkg::ADDR_MARGIN_HI: next_st.regs.margin_hi = I_CMD.wdata;
                vcf_pkg::ADDR_MARGIN_LO: next_st.regs.margin_lo = I_CMD.wdata;
                vcf_pkg::ADDR_RAMP:      next_st.regs.ramp = clamp_ramp(I_CMD.wdata);
                vcf_pkg::ADDR_SLOPE:     next_st.regs.slope = I_CMD.wdata;
                vcf_pkg::ADDR_LOOP_GAIN: next_st.regs.loop_gain = I_CMD.wdata;
                vcf_pkg::ADDR_MON_SCALE: next_st.regs.mon_scale = I_CMD.wdata;
                vcf_pkg::ADDR_DUTY:      next_st.regs.duty = I_CMD.wdata;
                vcf_pkg::ADDR_VIN_ON:    next_st.regs.vin_on = I_CMD.wdata;
                vcf_pkg::ADDR_VIN_OFF:   next_st.regs.vin_off = I_CMD.wdata;
                vcf_pkg::ADDR_IOFFSET:   next_st.regs.ioffset = I_CMD.wdata;
                vcf_pkg::ADDR_OV_LIMIT:  next_st.regs.ov_limit = I_CMD.wdata;
                vcf_pkg::ADDR_OV_RESP:   next_st.regs.ov_resp = I_CMD.wdata[7:0];
                default:                 next_st.refused = 1'b1;
            endcase
        end

        if (I_CMD.rd) begin
            next_st.rvalid = 1'b1;
            unique case (I_CMD.addr)
                vcf_pkg::ADDR_CEILING:   next_st.rdata = st.regs.ceiling;
                vcf_pkg::ADDR_MARGIN_HI: next_st.rdata = st.regs.margin_hi;
                vcf_pkg::ADDR_MARGIN_LO: next_st.rdata = st.regs.margin_lo;
                vcf_pkg::ADDR_RAMP:      next_st.rdata = st.regs.ramp;
                vcf_pkg::ADDR_SLOPE:     next_st.rdata = st.regs.slope;
                vcf_pkg::ADDR_LOOP_GAIN: next_st.rdata = st.regs.loop_gain;
                vcf_pkg::ADDR_MON_SCALE: next_st.rdata = st.regs.mon_scale;
                vcf_pkg::ADDR_DUTY:      next_st.rdata = st.regs.duty;
                vcf_pkg::ADDR_FSW:       next_st.rdata = vcf_pkg::FSW_KHZ;
                vcf_pkg::ADDR_VIN_ON:    next_st.rdata = st.regs.vin_on;
                vcf_pkg::ADDR_VIN_OFF:   next_st.rdata = st.regs.vin_off;
                vcf_pkg::ADDR_IOFFSET:   next_st.rdata = st.regs.ioffset;
                vcf_pkg::ADDR_OV_LIMIT:  next_st.rdata = st.regs.ov_limit;
                vcf_pkg::ADDR_OV_RESP:   next_st.rdata = {8'h00, st.regs.ov_resp};
                default:                 next_st.rdata = 16'h0000;
            endcase
        end

        if (I_MARGIN_HIGH) begin
            goal = st.regs.margin_hi;
        end else if (I_MARGIN_LOW) begin
            goal = st.regs.margin_lo;
        end else begin
            goal = I_VOUT_COMMAND;
        end
        if (goal > st.regs.ceiling) begin
            goal = st.regs.ceiling;
        end
        droop = 16'((32'(st.regs.slope) * 32'(I_LOAD_CURRENT)) >> 10);
        goal = (goal > droop) ? 16'(goal - droop) : 16'h0000;

        if (st.tick >= vcf_pkg::RAMP_TICK_CYC - 16'h0001) begin
            next_st.tick = 16'h0000;
            next_st.target = step_toward(st.target, goal, st.regs.ramp);
        end else begin
            next_st.tick = 16'(st.tick + 16'h0001);
        end

        ov_now = I_VOUT_SENSE > st.regs.ov_limit;
        // Set wins over clear so a fault landing on a clear is kept.
        if (ov_now && resp != 2'b00) begin
            next_st.ov_flag = 1'b1;
        end else if (I_CLEAR_FAULTS || I_CLEAR_OV_BIT || off_on) begin
            next_st.ov_flag = 1'b0;
        end

        unique case (st.run)
            vcf_pkg::VCF_OFF: begin
                next_st.delay_cnt = 16'h0000;
                if (I_ENABLE && I_VIN_MEAS >= st.regs.vin_on) begin
                    next_st.run = vcf_pkg::VCF_RUN;
                    next_st.retries = 3'h0;
                end
            end
            vcf_pkg::VCF_RUN: begin
                if (!I_ENABLE || I_VIN_MEAS <= st.regs.vin_off) begin
                    next_st.run = vcf_pkg::VCF_OFF;
                end else if (ov_now) begin
                    unique case (resp)
                        2'b00: next_st.delay_cnt = 16'h0000;
                        2'b01: begin
                            if (st.delay_cnt >= delay_len) begin
                                next_st.run = vcf_pkg::VCF_LATCHED;
                            end else begin
                                next_st.delay_cnt = 16'(st.delay_cnt + 16'h0001);
                            end
                        end
                        2'b10: next_st.run = vcf_pkg::VCF_LATCHED;
                        2'b11: next_st.run = vcf_pkg::VCF_HOLD;
                    endcase
                end else begin
                    next_st.delay_cnt = 16'h0000;
                end
            end
            vcf_pkg::VCF_HOLD: begin
                if (!I_ENABLE) begin
                    next_st.run = vcf_pkg::VCF_OFF;
                end else if (!ov_now) begin
                    next_st.run = vcf_pkg::VCF_RUN;
                end
            end
            vcf_pkg::VCF_LATCHED: begin
                next_st.delay_cnt = 16'(st.delay_cnt + 16'h0001);
                if (I_CLEAR_FAULTS || I_CLEAR_OV_BIT || !I_ENABLE) begin
                    next_st.run = vcf_pkg::VCF_OFF;
                end else if (retry_set != 3'b000 && st.delay_cnt >= delay_len
                             && (retry_set == 3'b111 || st.retries < retry_set)) begin
                    next_st.run = vcf_pkg::VCF_RUN;
                    next_st.delay_cnt = 16'h0000;
                    next_st.retries = 3'(st.retries + 3'h1);
                end
            end
        endcase

        next_st.duty = (I_DUTY_DEMAND > st.regs.duty) ? st.regs.duty : I_DUTY_DEMAND;
        next_st.iout = 16'(I_IOUT_RAW + st.regs.ioffset);
        next_st.vloop = I_VOUT_SENSE * st.regs.loop_gain;
        next_st.vmon = I_VOUT_SENSE * st.regs.mon_scale;
        next_st.vexp = I_VOUT_MODE[vcf_pkg::EXP_HI:0];
    end

    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            st                <= '0;
            st.regs.ceiling   <= vcf_pkg::RST_CEILING;
            st.regs.margin_hi <= vcf_pkg::RST_MARGIN;
            st.regs.margin_lo <= vcf_pkg::RST_MARGIN;
            st.regs.ramp      <= vcf_pkg::RST_RAMP;
            st.regs.slope     <= vcf_pkg::RST_WORD;
            st.regs.loop_gain <= vcf_pkg::RST_WORD;
            st.regs.mon_scale <= vcf_pkg::RST_WORD;
            st.regs.duty      <= vcf_pkg::RST_DUTY;
            st.regs.vin_on    <= vcf_pkg::RST_WORD;
            st.regs.vin_off   <= vcf_pkg::RST_WORD;
            st.regs.ioffset   <= vcf_pkg::RST_WORD;
            st.regs.ov_limit  <= vcf_pkg::RST_OV_LIMIT;
            st.regs.ov_resp   <= vcf_pkg::RST_OV_RESP;
            st.run            <= vcf_pkg::VCF_OFF;
        end else begin
            st <= next_st;
        end
    end

    always_comb begin
        O_RDATA        = st.rdata;
        O_RVALID       = st.rvalid;
        O_WR_REFUSED   = st.refused;
        O_CONVERTING   = st.run == vcf_pkg::VCF_RUN;
        O_OUTPUT_EN    = st.run == vcf_pkg::VCF_RUN;
        O_OV_FAULT     = st.ov_flag;
        O_VOUT_TARGET  = st.target;
        O_DUTY         = st.duty;
        O_IOUT_REPORT  = st.iout;
        O_VOUT_LOOP    = st.vloop;
        O_VOUT_MONITOR = st.vmon;
        O_VOUT_EXP     = st.vexp;
    end

endmodule

// File: core/vcf_pkg.sv
// Package for the output-voltage configuration and over-voltage fault command bank.
package vcf_pkg;

    localparam logic [7:0]  ADDR_CEILING    = 8'h24;
    localparam logic [7:0]  ADDR_MARGIN_HI  = 8'h25;
    localparam logic [7:0]  ADDR_MARGIN_LO  = 8'h26;
    localparam logic [7:0]  ADDR_RAMP       = 8'h27;
    localparam logic [7:0]  ADDR_SLOPE      = 8'h28;
    localparam logic [7:0]  ADDR_LOOP_GAIN  = 8'h29;
    localparam logic [7:0]  ADDR_MON_SCALE  = 8'h2a;
    localparam logic [7:0]  ADDR_DUTY       = 8'h32;
    localparam logic [7:0]  ADDR_FSW        = 8'h33;
    localparam logic [7:0]  ADDR_VIN_ON     = 8'h35;
    localparam logic [7:0]  ADDR_VIN_OFF    = 8'h36;
    localparam logic [7:0]  ADDR_IOFFSET    = 8'h39;
    localparam logic [7:0]  ADDR_OV_LIMIT   = 8'h40;
    localparam logic [7:0]  ADDR_OV_RESP    = 8'h41;

    // Reset values in linear format: exponent 0, mantissa in the unit.
    localparam logic [15:0] RST_CEILING     = 16'hffff;
    localparam logic [15:0] RST_MARGIN      = 16'h0000;
    localparam logic [15:0] RST_RAMP        = 16'h0001;
    localparam logic [15:0] RST_WORD        = 16'h0000;
    localparam logic [15:0] RST_DUTY        = 16'h0064;
    localparam logic [15:0] RST_OV_LIMIT    = 16'hffff;
    localparam logic [7:0]  RST_OV_RESP     = 8'h80;
    localparam logic [15:0] FSW_KHZ         = 16'h00c8;

    localparam logic [15:0] RAMP_MIN        = 16'h0001;
    localparam logic [15:0] RAMP_MAX        = 16'h000a;
    // 110 percent ceiling factor as a ratio.
    localparam logic [7:0]  CEIL_NUM        = 8'h0b;
    localparam logic [7:0]  CEIL_DEN        = 8'h0a;

    localparam int          RESP_HI         = 7;
    localparam int          RESP_LO         = 6;
    localparam int          RETRY_HI        = 5;
    localparam int          RETRY_LO        = 3;
    localparam int          DELAY_HI        = 2;
    localparam int          DELAY_LO        = 0;
    localparam int          EXP_HI          = 4;

    // One unit of the response delay field.
    localparam int          DELAY_UNIT_US   = 10;
    localparam int          CLK_MHZ         = 100;
    localparam logic [15:0] DELAY_UNIT_CYC  = 16'(DELAY_UNIT_US * CLK_MHZ);
    // Ramp step period: one mantissa unit per microsecond per V/ms.
    localparam logic [15:0] RAMP_TICK_CYC   = 16'(CLK_MHZ);

    typedef enum logic [1:0] {
        VCF_RESP_IGNORE,
        VCF_RESP_DELAY,
        VCF_RESP_DISABLE,
        VCF_RESP_FOLLOW
    } vcf_resp_t;

    typedef enum logic [1:0] {
        VCF_OFF,
        VCF_RUN,
        VCF_HOLD,
        VCF_LATCHED
    } vcf_run_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } vcf_cmd_t;

    typedef struct packed {
        logic [15:0] ceiling;
        logic [15:0] margin_hi;
        logic [15:0] margin_lo;
        logic [15:0] ramp;
        logic [15:0] slope;
        logic [15:0] loop_gain;
        logic [15:0] mon_scale;
        logic [15:0] duty;
        logic [15:0] vin_on;
        logic [15:0] vin_off;
        logic [15:0] ioffset;
        logic [15:0] ov_limit;
        logic [7:0]  ov_resp;
    } vcf_regs_t;

endpackage

// File: tb/vcf_bank_monitor.sv
// Port checker of the command bank.
`timescale 1ns/1ps
module vcf_bank_monitor (
    input wire logic              I_CLK_SYS,
    input wire logic              I_RST,
    input wire vcf_pkg::vcf_cmd_t I_CMD,
    input wire logic [15:0]       I_STRAP_NOMINAL,
    input wire logic [7:0]        I_VOUT_MODE,
    input wire logic              I_ENABLE,
    input wire logic              I_CLEAR_FAULTS,
    input wire logic              I_CLEAR_OV_BIT,
    input wire logic [15:0]       I_VIN_MEAS,
    input wire logic [15:0]       I_VOUT_SENSE,
    input wire logic [15:0]       O_RDATA,
    input wire logic              O_RVALID,
    input wire logic              O_WR_REFUSED,
    input wire logic              O_OUTPUT_EN,
    input wire logic              O_OV_FAULT,
    input wire logic [15:0]       O_VOUT_TARGET,
    input wire logic [4:0]        O_VOUT_EXP
);
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RST);
    logic [7:0]  resp;
    logic [15:0] lim;
    logic [15:0] voff;
    logic        ov_run;
    logic        ceil_over;
    // Shadows follow the same writes the bank takes, so the fault mode is known here.
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            resp <= vcf_pkg::RST_OV_RESP;
            lim  <= vcf_pkg::RST_OV_LIMIT;
            voff <= vcf_pkg::RST_WORD;
        end else if (I_CMD.wr) begin
            if (I_CMD.addr == vcf_pkg::ADDR_OV_RESP) resp <= I_CMD.wdata[7:0];
            if (I_CMD.addr == vcf_pkg::ADDR_OV_LIMIT) lim <= I_CMD.wdata;
            if (I_CMD.addr == vcf_pkg::ADDR_VIN_OFF) voff <= I_CMD.wdata;
        end
    end
    assign ov_run = O_OUTPUT_EN && I_ENABLE && I_VIN_MEAS > voff && I_VOUT_SENSE > lim
        && !I_CLEAR_FAULTS && !I_CLEAR_OV_BIT;
    assign ceil_over = 32'(I_CMD.wdata) * 32'(vcf_pkg::CEIL_DEN)
        > 32'(I_STRAP_NOMINAL) * 32'(vcf_pkg::CEIL_NUM);
    sequence s_trip(logic [1:0] mode);
        ov_run && resp[7:6] == mode;
    endsequence
    sequence s_latched;
        O_OV_FAULT && !O_OUTPUT_EN && I_ENABLE && $past(I_ENABLE) && resp[7:3] == 5'h10
            && !I_CLEAR_FAULTS && !I_CLEAR_OV_BIT;
    endsequence
    a_read_answer:
        assert property (I_CMD.rd |=> O_RVALID) else $error("read got no answer");
    a_fsw_refused:
        assert property (I_CMD.wr && I_CMD.addr == vcf_pkg::ADDR_FSW |=> O_WR_REFUSED)
        else $error("frequency write not refused");
    a_fsw_value:
        assert property (I_CMD.rd && I_CMD.addr == vcf_pkg::ADDR_FSW
            |=> O_RDATA == vcf_pkg::FSW_KHZ) else $error("frequency read wrong");
    a_ceiling_check:
        assert property (I_CMD.wr && I_CMD.addr == vcf_pkg::ADDR_CEILING
            |=> O_WR_REFUSED == $past(ceil_over)) else $error("ceiling refusal wrong");
    a_exp_follow:
        assert property ($stable(I_VOUT_MODE)[*3] |-> O_VOUT_EXP == I_VOUT_MODE[4:0])
        else $error("exponent does not follow mode");
    a_ramp_step:
        assert property ($changed(O_VOUT_TARGET) |->
            O_VOUT_TARGET - $past(O_VOUT_TARGET) <= vcf_pkg::RAMP_MAX
            || $past(O_VOUT_TARGET) - O_VOUT_TARGET <= vcf_pkg::RAMP_MAX)
        else $error("target step too large");
    a_ov_ignore:
        assert property (s_trip(2'b00) |=> O_OUTPUT_EN && !$rose(O_OV_FAULT))
        else $error("ignored fault interrupted output");
    a_ov_disable:
        assert property (s_trip(2'b10) |=> !O_OUTPUT_EN) else $error("fault did not disable");
    a_ov_follow:
        assert property (s_trip(2'b11) |=> !O_OUTPUT_EN) else $error("fault did not hold");
    a_latched_off:
        assert property (s_latched |=> !O_OUTPUT_EN) else $error("restart without retry");
    a_clear_flag:
        assert property ((I_CLEAR_FAULTS || I_CLEAR_OV_BIT) && I_VOUT_SENSE <= lim
            |=> !O_OV_FAULT) else $error("clear left fault flag");
endmodule
bind vcf_bank vcf_bank_monitor vcf_bank_monitor_i (
    .I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_CMD(I_CMD), .I_STRAP_NOMINAL(I_STRAP_NOMINAL),
    .I_VOUT_MODE(I_VOUT_MODE), .I_ENABLE(I_ENABLE), .I_CLEAR_FAULTS(I_CLEAR_FAULTS),
    .I_CLEAR_OV_BIT(I_CLEAR_OV_BIT), .I_VIN_MEAS(I_VIN_MEAS), .I_VOUT_SENSE(I_VOUT_SENSE),
    .O_RDATA(O_RDATA), .O_RVALID(O_RVALID), .O_WR_REFUSED(O_WR_REFUSED),
    .O_OUTPUT_EN(O_OUTPUT_EN), .O_OV_FAULT(O_OV_FAULT), .O_VOUT_TARGET(O_VOUT_TARGET),
    .O_VOUT_EXP(O_VOUT_EXP));

// File: tb/vcf_bank_tb_top.sv
// Self-checking testbench of the command bank.
`timescale 1ns/1ps
module vcf_bank_tb_top;
    logic        clk = 1'b0, rst = 1'b1, mhi = 1'b0, mlo = 1'b0, en = 1'b0, clrb = 1'b0;
    logic [15:0] strap = 16'h0064, vcmd = 16'h0000, vin = 16'h0040, vsense = 16'h0010;
    logic [15:0] iraw = 16'h0100, load = 16'h0000, dem = 16'h0070, rdata, tgt, duty, irep;
    logic [7:0]  mode = 8'h1b;
    logic [31:0] vloop, vmon;
    logic [4:0]  vexp;
    logic        rvalid, refused, conv, outen, fault, clr;
    vcf_pkg::vcf_cmd_t cmd;
    int          num_errors = 0, total_checks = 0, cycles = 0;
    localparam logic [7:0] AD [14] = '{8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2a,
        8'h32, 8'h33, 8'h35, 8'h36, 8'h39, 8'h40, 8'h41};
    localparam logic [15:0] DV [14] = '{16'hffff, 16'h0000, 16'h0000, 16'h0001, 16'h0000,
        16'h0000, 16'h0000, 16'h0064, 16'h00c8, 16'h0000, 16'h0000, 16'h0000, 16'hffff, 16'h0080};
    always #5 clk = ~clk;
    vcf_bank vcf_bank_i (.I_CLK_SYS(clk), .I_RST(rst), .I_CMD(cmd), .I_STRAP_NOMINAL(strap),
        .I_VOUT_MODE(mode), .I_VOUT_COMMAND(vcmd), .I_MARGIN_HIGH(mhi), .I_MARGIN_LOW(mlo),
        .I_ENABLE(en), .I_CLEAR_FAULTS(clr), .I_CLEAR_OV_BIT(clrb), .I_VIN_MEAS(vin),
        .I_VOUT_SENSE(vsense), .I_IOUT_RAW(iraw), .I_LOAD_CURRENT(load), .I_DUTY_DEMAND(dem),
        .O_RDATA(rdata), .O_RVALID(rvalid), .O_WR_REFUSED(refused), .O_CONVERTING(conv),
        .O_OUTPUT_EN(outen), .O_OV_FAULT(fault), .O_VOUT_TARGET(tgt), .O_DUTY(duty),
        .O_IOUT_REPORT(irep), .O_VOUT_LOOP(vloop), .O_VOUT_MONITOR(vmon), .O_VOUT_EXP(vexp));
    vcf_host vcf_host_i (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid),
        .i_refused(refused), .o_cmd(cmd), .o_clear(clr));
    task automatic chkw(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chkb(input string n, input logic e, input logic g);
        chkw(n, {31'h0, e}, {31'h0, g});
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic r);
        logic [15:0] q;
        logic v, f;
        vcf_host_i.xfer(1'b1, a, d, q, v, f);
        chkb("write refused", r, f);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] q;
        logic v, f;
        vcf_host_i.xfer(1'b0, a, 16'h0000, q, v, f);
        chkb("read valid", 1'b1, v);
        chkw($sformatf("register %h", a), {16'h0, e}, {16'h0, q});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // The whole run needs a few thousand cycles; the ceiling leaves ample margin.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            conclude();
        end
    end
    initial begin
        cyc(16);
        rst <= 1'b0;
        for (int i = 0; i < 14; i++) rd(AD[i], DV[i]);
        for (int i = 0; i < 14; i++) wr(AD[i], 16'h0005 + 16'(i), i == 8);
        for (int i = 0; i < 14; i++) rd(AD[i], i == 8 ? 16'h00c8 : 16'h0005 + 16'(i));
        $display("test defaults and readback done");
        vcf_host_i.gap = 3;
        wr(vcf_pkg::ADDR_CEILING, 16'h006e, 1'b0);
        wr(vcf_pkg::ADDR_CEILING, 16'h006f, 1'b1);
        rd(vcf_pkg::ADDR_CEILING, 16'h006e);
        vcf_host_i.gap = 0;
        wr(vcf_pkg::ADDR_RAMP, 16'h0000, 1'b0);
        rd(vcf_pkg::ADDR_RAMP, 16'h0001);
        wr(vcf_pkg::ADDR_RAMP, 16'h0020, 1'b0);
        rd(vcf_pkg::ADDR_RAMP, 16'h000a);
        wr(8'h50, 16'h1234, 1'b1);
        rd(8'h50, 16'h0000);
        $display("test limits done");
        wr(vcf_pkg::ADDR_VIN_ON, 16'h0030, 1'b0);
        wr(vcf_pkg::ADDR_VIN_OFF, 16'h0020, 1'b0);
        wr(vcf_pkg::ADDR_OV_LIMIT, 16'h0100, 1'b0);
        wr(vcf_pkg::ADDR_OV_RESP, 16'h0000, 1'b0);
        vin <= 16'h002f;
        en <= 1'b1;
        cyc(5);
        chkb("converting", 1'b0, conv);
        vin <= 16'h0030;
        cyc(5);
        chkb("converting", 1'b1, conv);
        vin <= 16'h0021;
        cyc(5);
        chkb("converting", 1'b1, conv);
        vin <= 16'h0020;
        cyc(5);
        chkb("converting", 1'b0, conv);
        vin <= 16'h0040;
        cyc(5);
        $display("test conversion thresholds done");
        wr(vcf_pkg::ADDR_RAMP, 16'h0001, 1'b0);
        wr(vcf_pkg::ADDR_MARGIN_HI, 16'h0008, 1'b0);
        wr(vcf_pkg::ADDR_MARGIN_LO, 16'h0003, 1'b0);
        mhi <= 1'b1;
        cyc(350);
        chkb("target ramping", 1'b1, tgt >= 16'h0002 && tgt <= 16'h0004);
        cyc(600);
        chkw("target", 32'h8, {16'h0, tgt});
        mhi <= 1'b0;
        mlo <= 1'b1;
        cyc(700);
        chkw("target", 32'h3, {16'h0, tgt});
        wr(vcf_pkg::ADDR_RAMP, 16'h000a, 1'b0);
        mhi <= 1'b1;
        cyc(150);
        chkw("target", 32'h8, {16'h0, tgt});
        load <= 16'h0200;
        cyc(150);
        chkw("target", 32'h4, {16'h0, tgt});
        load <= 16'h0000;
        $display("test ramp done");
        cyc(5);
        chkw("duty", 32'hc, {16'h0, duty});
        chkw("current report", 32'h110, {16'h0, irep});
        chkw("loop voltage", 32'ha0, vloop);
        chkw("monitor voltage", 32'hb0, vmon);
        chkw("exponent", 32'h1b, {27'h0, vexp});
        wr(vcf_pkg::ADDR_IOFFSET, 16'hffff, 1'b0);
        dem <= 16'h0003;
        cyc(5);
        chkw("duty", 32'h3, {16'h0, duty});
        chkw("current report", 32'hff, {16'h0, irep});
        $display("test datapath done");
        vsense <= 16'h0200;
        cyc(5);
        chkb("output on", 1'b1, outen);
        chkb("fault flag", 1'b0, fault);
        vsense <= 16'h0010;
        wr(vcf_pkg::ADDR_OV_RESP, 16'h0080, 1'b0);
        for (int k = 0; k < 3; k++) begin
            vsense <= 16'h0200;
            cyc(3);
            chkb("output on", 1'b0, outen);
            chkb("fault flag", 1'b1, fault);
            vsense <= 16'h0010;
            cyc(50);
            chkb("output on", 1'b0, outen);
            if (k == 0) vcf_host_i.clear();
            else if (k == 1) begin
                clrb <= 1'b1;
                cyc(1);
                clrb <= 1'b0;
            end else begin
                en <= 1'b0;
                cyc(3);
                en <= 1'b1;
            end
            cyc(5);
            chkb("fault flag", 1'b0, fault);
            chkb("output on", 1'b1, outen);
        end
        wr(vcf_pkg::ADDR_OV_RESP, 16'h00c0, 1'b0);
        vsense <= 16'h0200;
        cyc(3);
        chkb("output on", 1'b0, outen);
        vsense <= 16'h0010;
        cyc(3);
        chkb("output on", 1'b1, outen);
        wr(vcf_pkg::ADDR_OV_RESP, 16'h0041, 1'b0);
        vsense <= 16'h0200;
        cyc(500);
        chkb("output on", 1'b1, outen);
        cyc(600);
        chkb("output on", 1'b0, outen);
        vsense <= 16'h0010;
        vcf_host_i.clear();
        cyc(5);
        chkb("output on", 1'b1, outen);
        $display("test fault responses done");
        conclude();
    end
endmodule

// File: tb/vcf_host.sv
// Host controller model issuing command reads, writes and fault clears.
`timescale 1ns/1ps
module vcf_host (
    input  wire logic         i_clk,
    input  wire logic [15:0]  i_rdata,
    input  wire logic         i_rvalid,
    input  wire logic         i_refused,
    output vcf_pkg::vcf_cmd_t o_cmd,
    output logic              o_clear
);
    int gap = 0;
    initial begin
        o_cmd = '0;
        o_clear = 1'b0;
    end
    // One request per call; the answer is sampled one cycle after the taking edge.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic v, output logic r);
        repeat (gap) @(posedge i_clk);
        @(posedge i_clk);
        o_cmd <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge i_clk);
        // A released bus shows inverted contents so stale values cannot pass.
        o_cmd <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        @(posedge i_clk);
        q = i_rdata;
        v = i_rvalid;
        r = i_refused;
    endtask
    task automatic clear();
        @(posedge i_clk);
        o_clear <= 1'b1;
        @(posedge i_clk);
        o_clear <= 1'b0;
    endtask
endmodule
